// ==== core/ppc_pkg.sv ====
// Constants shared by the pixel clock loop and power state controller
// Overview of operation
// (R01) Divide generated pixel count, compare with sync, trim oscillator frequency to hold lock
// (R02) Divisor is 12 bits; host keeps it between 221 and 4095
// (R03) Effective divide ratio is the programmed divisor plus one
// (R04) Sync reference of 15 to 110 kHz accepted, pixel clock 12 to 110 MHz; band 3 here reaches 140 MHz
// (R05) Two-bit band field picks one of four oscillator frequency bands
// (R06) Three-bit pump field sets loop drive, 50 to 1500 microamps
// (R07) Five-bit phase field shifts sampling clock in 32 steps of 11.25 degrees
// (R08) Aligned sync output copies sync with the same phase shift
// (R09) While coast is active the loop keeps its present frequency
// (R10) Coast active level is programmable
// (R11) Sync active level is programmable
// (R12) Host sets both polarities to match real inputs when not auto-detecting
// (R13) Power state derives from activity detectors, interface bits and power-down bit
// (R14) Full power with bit 1 and sync, seek with bit 1 alone, else down
// (R15) Power-down command overrides the automatic activity-based selection
// (R16) Power-down control is bit 1 of register 0FH, zero requests power-down
// (R17) Sync detected is the OR of bits 7, 4 and 1 of register 14H
// (R18) Only bus, activity detect, slicer and bandgap stay powered outside full power
// (R19) Host uses recommended band and pump codes for standard formats
// (R20) Divisor high byte in 01H, low nibble in 02H bits 7:4, high first
// (R21) Band field is 03H bits 7:6, pump field is 03H bits 5:3
// (R22) Phase field is 04H bits 7:3; larger means more delay, step T/32
// (R23) Coast is asynchronous and disables the loop reference input
// (R24) Coast gates the comparator so the frequency word holds its last value
package ppc_pkg;

  // ****************************************
  // Register map and reset values
  // ****************************************
  localparam logic [7:0] ADDR_REV     = 8'h00;
  localparam logic [7:0] ADDR_DIV_HI  = 8'h01;
  localparam logic [7:0] ADDR_DIV_LO  = 8'h02;
  localparam logic [7:0] ADDR_LOOP    = 8'h03;
  localparam logic [7:0] ADDR_PHASE   = 8'h04;
  localparam logic [7:0] ADDR_POL     = 8'h0E;
  localparam logic [7:0] ADDR_PWR     = 8'h0F;
  localparam logic [7:0] ADDR_ACT     = 8'h14;
  localparam logic [7:0] RST_DIV_HI   = 8'h69;
  localparam logic [7:0] RST_DIV_LO   = 8'hD0;
  localparam logic [7:0] RST_LOOP     = 8'h48;
  localparam logic [7:0] RST_PHASE    = 8'h80;
  localparam logic [7:0] RST_POL      = 8'h48;
  localparam logic [7:0] RST_PWR      = 8'h02;
  localparam logic [7:0] REV_CODE     = 8'h00; // Arbitrary revision value

  // ****************************************
  // Field positions
  // ****************************************
  localparam int POS_BAND     = 6;
  localparam int POS_PUMP     = 3;
  localparam int POS_PHASE    = 3;
  localparam int POS_DIV_LO   = 4;
  localparam int POS_PD       = 1;
  localparam int POS_HS_POL   = 6;
  localparam int POS_CST_POL  = 3;
  localparam int POS_ACT_HS   = 7;
  localparam int POS_ACT_B    = 4;
  localparam int POS_ACT_C    = 1;

  // ****************************************
  // Timing, in its own units and in cycles
  // ****************************************
  localparam int CLK_HZ       = 20_000_000;
  localparam int HS_MIN_HZ    = 15_000;
  localparam int HS_MAX_HZ    = 110_000;
  localparam int PER_MIN_CYC  = CLK_HZ / HS_MAX_HZ;
  localparam int PER_MAX_CYC  = CLK_HZ / HS_MIN_HZ;
  localparam int ACT_TMO_US   = 200;
  localparam int ACT_TMO_CYC  = ACT_TMO_US * (CLK_HZ / 1_000_000);

  // ****************************************
  // Loop arithmetic
  // ****************************************
  localparam int FRAC         = 16;
  localparam int FCW_W        = 19;
  localparam int LOOP_SHIFT   = 2;
  localparam int LOCK_TOL     = 2;
  localparam int CLK_MHZ      = 20;
  localparam int BAND0_LO_MHZ = 12;
  localparam int BAND1_LO_MHZ = 32;
  localparam int BAND2_LO_MHZ = 64;
  localparam int BAND3_LO_MHZ = 110;
  localparam int BAND3_HI_MHZ = 140;
  localparam logic [FCW_W-1:0] RST_FCW = FCW_W'((65 * (1 << FRAC)) / CLK_MHZ);

  typedef enum logic [1:0] {PPC_FULL, PPC_SEEK, PPC_DOWN} ppc_pwr_e;

endpackage

// ==== core/ppc_sync3.sv ====
// Three-stage synchroniser with agreement filter for one asynchronous pin
`timescale 1ns/100ps
module ppc_sync3 (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic pin_in,
  output logic      level_ff
);

  logic s1_ff;
  logic s2_ff;
  logic s3_ff;

  // Chain; the first stage feeds only the second
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s1_ff <= 1'b0;
      s2_ff <= 1'b0;
      s3_ff <= 1'b0;
    end else begin
      s1_ff <= pin_in;
      s2_ff <= s1_ff;
      s3_ff <= s2_ff;
    end
  end

  // Accept a change only once two settled stages agree
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      level_ff <= 1'b0;
    end else if (s2_ff == s3_ff) begin
      level_ff <= s2_ff;
    end
  end

endmodule

// ==== core/ppc_act_det.sv ====
// Sync activity detector: active while edges keep arriving before timeout
`timescale 1ns/100ps
module ppc_act_det #(
  parameter int TMO_CYC = ppc_pkg::ACT_TMO_CYC
) (
  input  wire logic clk,
  input  wire logic rst_b,
  input  wire logic edge_in,
  output logic      active_ff
);
  import ppc_pkg::*;

  localparam int CW = $clog2(TMO_CYC + 1);

  logic [CW-1:0] cnt_ff;

  // Restart on every edge, saturate at timeout
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cnt_ff    <= '0;
      active_ff <= 1'b0;
    end else if (edge_in) begin
      cnt_ff    <= '0;
      active_ff <= 1'b1;
    end else if (cnt_ff == CW'(TMO_CYC)) begin
      active_ff <= 1'b0;
    end else begin
      cnt_ff <= cnt_ff + CW'(1);
    end
  end

endmodule

// ==== core/ppc_top.sv ====
// Pixel clock loop control, polarity, coast and power state selection
`timescale 1ns/100ps
module ppc_top #(
  parameter logic [7:0] REV = ppc_pkg::REV_CODE // Arbitrary value
) (
  input  wire logic                       clk,
  input  wire logic                       rst_b,
  input  wire logic                       hsync_pin,
  input  wire logic                       coast_pin,
  input  wire logic [1:0]                 aux_sync_act,
  input  wire logic [7:0]                 reg_addr,
  input  wire logic [7:0]                 reg_wdata,
  input  wire logic                       reg_wr,
  input  wire logic                       reg_rd,
  output logic      [7:0]                 reg_rdata_ff,
  output logic      [ppc_pkg::FCW_W-1:0]  freq_word_ff,
  output logic                            loop_lock_ff,
  output logic      [4:0]                 sample_phase_ff,
  output logic                            aligned_sync_out_ff,
  output logic      [4:0]                 aligned_sync_phase_ff,
  output logic      [1:0]                 osc_band_field_ff,
  output logic      [2:0]                 pump_current_ff,
  output logic                            core_power_on_ff,
  output logic                            seek_mode_ff
);
  import ppc_pkg::*;

  // ****************************************
  // Register storage
  // ****************************************
  logic [7:0]       div_stage_ff;
  logic [11:0]      divisor_ff;
  logic [7:0]       div_lo_ff;
  logic             hs_pol_ff;
  logic             cst_pol_ff;
  logic             pd_bit_ff;
  ppc_pwr_e         pwr_ff;
  ppc_pwr_e         nxt_pwr;

  // Loop state
  logic [FRAC-1:0]  acc_ff;
  logic [12:0]      pix_cnt_ff;
  logic [10:0]      per_cnt_ff;
  logic             resync_ff;
  logic             hs_prev_ff;

  // Synchronised pins and derived levels
  logic             hs_sync;
  logic             cst_sync;
  logic             hs_act;
  logic             coast_act;
  logic             hs_edge;
  logic             hs_alive;
  logic [7:0]       act_reg;
  logic             sync_det;

  // Divisor write, high part staged so one update never mixes halves
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      div_stage_ff <= RST_DIV_HI;
      divisor_ff   <= {RST_DIV_HI, RST_DIV_LO[7:4]};
      div_lo_ff    <= RST_DIV_LO;
    end else if (reg_wr && reg_addr == ADDR_DIV_HI) begin
      div_stage_ff <= reg_wdata; // [R20]
    end else if (reg_wr && reg_addr == ADDR_DIV_LO) begin
      div_lo_ff    <= {reg_wdata[7:4], 4'h0};
      divisor_ff   <= {div_stage_ff, reg_wdata[7:POS_DIV_LO]}; // [R20] [R02]
    end
  end

  // Band, pump and phase fields
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_band_field_ff <= RST_LOOP[POS_BAND +: 2];
      pump_current_ff   <= RST_LOOP[POS_PUMP +: 3];
      sample_phase_ff   <= RST_PHASE[POS_PHASE +: 5];
    end else if (reg_wr && reg_addr == ADDR_LOOP) begin
      osc_band_field_ff <= reg_wdata[POS_BAND +: 2]; // [R21] [R05]
      pump_current_ff   <= reg_wdata[POS_PUMP +: 3]; // [R21] [R06]
    end else if (reg_wr && reg_addr == ADDR_PHASE) begin
      sample_phase_ff   <= reg_wdata[POS_PHASE +: 5]; // [R22] [R07]
    end
  end

  // Polarity and power-down control bits
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_pol_ff  <= RST_POL[POS_HS_POL];
      cst_pol_ff <= RST_POL[POS_CST_POL];
      pd_bit_ff  <= RST_PWR[POS_PD];
    end else if (reg_wr && reg_addr == ADDR_POL) begin
      hs_pol_ff  <= reg_wdata[POS_HS_POL]; // [R11]
      cst_pol_ff <= reg_wdata[POS_CST_POL]; // [R10]
    end else if (reg_wr && reg_addr == ADDR_PWR) begin
      pd_bit_ff  <= reg_wdata[POS_PD]; // [R16]
    end
  end

  // Read-back; unmapped addresses return zero
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      reg_rdata_ff <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        ADDR_REV:    reg_rdata_ff <= REV;
        ADDR_DIV_HI: reg_rdata_ff <= div_stage_ff;
        ADDR_DIV_LO: reg_rdata_ff <= div_lo_ff;
        ADDR_LOOP:   reg_rdata_ff <= {osc_band_field_ff, pump_current_ff, 3'b000};
        ADDR_PHASE:  reg_rdata_ff <= {sample_phase_ff, 3'b000};
        ADDR_POL:    reg_rdata_ff <= 8'((hs_pol_ff << POS_HS_POL) | (cst_pol_ff << POS_CST_POL));
        ADDR_PWR:    reg_rdata_ff <= 8'(pd_bit_ff << POS_PD);
        ADDR_ACT:    reg_rdata_ff <= act_reg;
        default:     reg_rdata_ff <= 8'h00;
      endcase
    end
  end

  // ****************************************
  // Input conditioning
  // ****************************************
  ppc_sync3 u_hs_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .pin_in   (hsync_pin),
    .level_ff (hs_sync)
  );

  // Coast is asynchronous to everything, so it gets its own chain
  ppc_sync3 u_cst_sync (
    .clk      (clk),
    .rst_b    (rst_b),
    .pin_in   (coast_pin), // [R23]
    .level_ff (cst_sync)
  );

  // Active levels after programmable polarity
  assign hs_act    = hs_pol_ff ? hs_sync : ~hs_sync; // [R11]
  assign coast_act = cst_pol_ff ? cst_sync : ~cst_sync; // [R10]
  assign hs_edge   = hs_act & ~hs_prev_ff;

  ppc_act_det u_hs_act (
    .clk       (clk),
    .rst_b     (rst_b),
    .edge_in   (hs_edge),
    .active_ff (hs_alive)
  );

  // Activity status word and the detect condition
  assign act_reg  = 8'((hs_alive << POS_ACT_HS) | (aux_sync_act[1] << POS_ACT_B)
                    | (aux_sync_act[0] << POS_ACT_C));
  assign sync_det = act_reg[POS_ACT_HS] | act_reg[POS_ACT_B] | act_reg[POS_ACT_C]; // [R17]

  // Aligned sync copy carries the same phase code as the sample clock
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      hs_prev_ff            <= 1'b0;
      aligned_sync_out_ff   <= 1'b0;
      aligned_sync_phase_ff <= RST_PHASE[POS_PHASE +: 5]; // Same code as the phase field
    end else begin
      hs_prev_ff            <= hs_act;
      aligned_sync_out_ff   <= hs_act; // [R08]
      aligned_sync_phase_ff <= sample_phase_ff; // [R08] [R22]
    end
  end

  // ****************************************
  // Power state
  // ****************************************
  // Power-down bit is tested first so the detectors can never override it
  always_comb begin
    if (!pd_bit_ff) begin
      nxt_pwr = PPC_DOWN; // [R15] [R14]
    end else if (sync_det) begin
      nxt_pwr = PPC_FULL; // [R14] [R13]
    end else begin
      nxt_pwr = PPC_SEEK; // [R14]
    end
  end

  // Only full power enables the loop; detectors and bus stay alive always
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pwr_ff           <= PPC_DOWN;
      core_power_on_ff <= 1'b0;
      seek_mode_ff     <= 1'b0;
    end else begin
      pwr_ff           <= nxt_pwr;
      core_power_on_ff <= (nxt_pwr == PPC_FULL); // [R18]
      seek_mode_ff     <= (nxt_pwr == PPC_SEEK);
    end
  end

  // ****************************************
  // Digital loop
  // ****************************************
  logic               per_ok;
  logic               ref_take;
  logic signed [13:0] err;
  logic [4:0]         gain;
  logic signed [22:0] delta;
  logic signed [22:0] fcw_raw;
  logic [FCW_W-1:0]   band_lo;
  logic [FCW_W-1:0]   band_hi;
  logic [FCW_W-1:0]   nxt_fcw;
  logic [FRAC:0]      acc_sum;

  // Period window rejects sync outside the reference range
  assign per_ok   = per_cnt_ff >= 11'(PER_MIN_CYC) && per_cnt_ff <= 11'(PER_MAX_CYC); // [R04]
  // Coast closes the reference gate, so no edge reaches the comparator
  assign ref_take = hs_edge && !coast_act && pwr_ff == PPC_FULL; // [R09] [R23]
  assign err      = $signed({1'b0, pix_cnt_ff}) - $signed({2'b00, divisor_ff} + 14'd1); // [R03]
  assign acc_sum  = {1'b0, acc_ff} + {1'b0, freq_word_ff[FRAC-1:0]};

  // Loop gain follows pump current in 50 uA units
  always_comb begin
    unique case (pump_current_ff)
      3'd0: gain = 5'd1;
      3'd1: gain = 5'd2;
      3'd2: gain = 5'd3;
      3'd3: gain = 5'd5;
      3'd4: gain = 5'd7;
      3'd5: gain = 5'd10;
      3'd6: gain = 5'd15;
      3'd7: gain = 5'd30; // [R06]
    endcase
  end

  // Band limits in pixels per system clock
  always_comb begin
    unique case (osc_band_field_ff)
      2'd0: begin
        band_lo = FCW_W'((BAND0_LO_MHZ << FRAC) / CLK_MHZ);
        band_hi = FCW_W'((BAND1_LO_MHZ << FRAC) / CLK_MHZ);
      end
      2'd1: begin
        band_lo = FCW_W'((BAND1_LO_MHZ << FRAC) / CLK_MHZ);
        band_hi = FCW_W'((BAND2_LO_MHZ << FRAC) / CLK_MHZ);
      end
      2'd2: begin
        band_lo = FCW_W'((BAND2_LO_MHZ << FRAC) / CLK_MHZ);
        band_hi = FCW_W'((BAND3_LO_MHZ << FRAC) / CLK_MHZ);
      end
      2'd3: begin
        band_lo = FCW_W'((BAND3_LO_MHZ << FRAC) / CLK_MHZ);
        band_hi = FCW_W'((BAND3_HI_MHZ << FRAC) / CLK_MHZ); // [R05]
      end
    endcase
  end

  // Trim frequency against the divided count, then clamp into the band
  always_comb begin
    delta   = 23'(err * $signed({1'b0, gain})) <<< LOOP_SHIFT;
    fcw_raw = $signed({4'h0, freq_word_ff});
    if (ref_take && !resync_ff && per_ok) begin
      fcw_raw = fcw_raw - delta; // [R01] [R24]
    end
    if (fcw_raw < $signed({4'h0, band_lo})) begin
      nxt_fcw = band_lo; // [R05]
    end else if (fcw_raw > $signed({4'h0, band_hi})) begin
      nxt_fcw = band_hi;
    end else begin
      nxt_fcw = fcw_raw[FCW_W-1:0];
    end
  end

  // Frequency word; frozen outside full power
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      freq_word_ff <= RST_FCW;
    end else if (pwr_ff == PPC_FULL) begin
      freq_word_ff <= nxt_fcw; // [R01]
    end
  end

  // Divided pixel count; oscillator runs free between edges and in coast
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      acc_ff     <= '0;
      pix_cnt_ff <= '0;
    end else if (ref_take) begin
      acc_ff     <= acc_sum[FRAC-1:0];
      pix_cnt_ff <= 13'(freq_word_ff[FCW_W-1:FRAC]) + 13'(acc_sum[FRAC]); // [R01]
    end else if (pwr_ff == PPC_FULL) begin
      acc_ff     <= acc_sum[FRAC-1:0];
      pix_cnt_ff <= 13'(pix_cnt_ff + freq_word_ff[FCW_W-1:FRAC] + acc_sum[FRAC]);
    end
  end

  // Sync period measure; edges during coast still restart it
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      per_cnt_ff <= '0;
    end else if (hs_edge) begin
      per_cnt_ff <= 11'd1;
    end else if (per_cnt_ff != '1) begin
      per_cnt_ff <= per_cnt_ff + 11'd1;
    end
  end

  // After coast or a bad period the first edge only restarts the count
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      resync_ff    <= 1'b1;
      loop_lock_ff <= 1'b0;
    end else if (pwr_ff != PPC_FULL) begin
      resync_ff    <= 1'b1;
      loop_lock_ff <= 1'b0;
    end else if (coast_act) begin
      resync_ff    <= 1'b1; // [R24]
    end else if (ref_take) begin
      resync_ff    <= !per_ok;
      loop_lock_ff <= !resync_ff && per_ok && err <= 14'sd2 && err >= -14'sd2;
    end
  end

  // ****************************************
  // Checks
  // ****************************************
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  pwr_down_a: assert property (!pd_bit_ff |=> !core_power_on_ff && !seek_mode_ff) // [R15]
    else $error("Power-down bit clear did not force power-down");
  pwr_full_a: assert property (pd_bit_ff && sync_det |=> core_power_on_ff) // [R14]
    else $error("Full power not entered with sync present");
  pwr_seek_a: assert property (pd_bit_ff && !sync_det |=> seek_mode_ff && !core_power_on_ff) // [R14]
    else $error("Seek mode not entered without sync");
  sync_det_a: assert property (sync_det == (hs_alive | aux_sync_act[1] | aux_sync_act[0])) // [R17]
    else $error("Sync detect is not the OR of the activity bits");
  coast_hold_a: assert property (coast_act && $stable(osc_band_field_ff) |=> $stable(freq_word_ff)) // [R24]
    else $error("Frequency word moved during coast");
  down_hold_a: assert property (pwr_ff != PPC_FULL |=> $stable(freq_word_ff)) // [R18]
    else $error("Loop ran outside full power");
  div_commit_a: assert property (reg_wr && reg_addr == ADDR_DIV_LO // [R20]
      |=> divisor_ff == {$past(div_stage_ff), $past(reg_wdata[7:4])})
    else $error("Divisor low write did not commit staged value");
  ratio_lock_a: assert property (ref_take && !resync_ff && per_ok // [R03]
      && pix_cnt_ff == 13'(divisor_ff) + 13'd1 && $stable(osc_band_field_ff)
      |=> $stable(freq_word_ff))
    else $error("Count equal to divisor plus one still moved frequency");
  range_rej_a: assert property (hs_edge && per_cnt_ff < 11'(PER_MIN_CYC) && !coast_act // [R04]
      && pwr_ff == PPC_FULL |=> resync_ff)
    else $error("Too short sync period was not rejected");
  align_a: assert property (aligned_sync_out_ff == $past(hs_act) // [R08]
      && aligned_sync_phase_ff == $past(sample_phase_ff))
    else $error("Aligned sync lost its phase or timing");
  band_a: assert property (pwr_ff == PPC_FULL && $stable(osc_band_field_ff) // [R05]
      |=> freq_word_ff >= $past(band_lo) && freq_word_ff <= $past(band_hi))
    else $error("Frequency word left its band");

  full_c:  cover property (seek_mode_ff ##1 core_power_on_ff);
  coast_c: cover property (coast_act && hs_edge && core_power_on_ff);
  lock_c:  cover property ($rose(loop_lock_ff));

endmodule

// ==== verif/ppc_src_model.sv ====
// Graphics source model: periodic sync pulses at a chosen polarity
`timescale 1ns/100ps
module ppc_src_model (
  input  wire logic        clk,
  input  wire logic        run,
  input  wire logic        act_high,
  input  wire logic [31:0] period,
  output logic             hsync_pin
);
  int cnt = 0;
  initial hsync_pin = 1'b0;
  // Pulses of 20 clocks, changed off the sampling edge; inactive level when stopped
  always @(negedge clk) begin
    cnt = (!run || cnt >= period - 1) ? 0 : cnt + 1;
    hsync_pin <= act_high ^ !(run && cnt < 20);
  end
endmodule

// ==== verif/test_pixel_pll_and_power_state_ctrl.sv ====
// Self-checking bench for the pixel clock loop and power state controller
`timescale 1ns/100ps
module test_pixel_pll_and_power_state_ctrl;
  import ppc_pkg::*;
  typedef struct packed {logic w; logic [7:0] a; logic [7:0] d; logic [7:0] q;} ppc_row_s;
  logic             clk = 0, rst_b = 0, coast_pin = 0, reg_wr = 0, reg_rd = 0;
  logic             run = 0, act_high = 1, hsync_pin, loop_lock_ff, aligned_sync_out_ff;
  logic             core_power_on_ff, seek_mode_ff;
  logic [1:0]       aux_sync_act = 2'h0, osc_band_field_ff;
  logic [2:0]       pump_current_ff;
  logic [4:0]       sample_phase_ff, aligned_sync_phase_ff;
  logic [7:0]       reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata_ff;
  logic [FCW_W-1:0] freq_word_ff, fw;
  int               period = 400, mismatches = 0, comparisons = 0, cycles = 0;
  // Reset reads first, then writes with read-back; all band and pump codes appear
  ppc_row_s rows [19] = '{
    '{0, ADDR_DIV_HI, 8'h00, RST_DIV_HI}, '{0, ADDR_DIV_LO, 8'h00, RST_DIV_LO},
    '{0, ADDR_LOOP, 8'h00, RST_LOOP}, '{0, ADDR_PHASE, 8'h00, RST_PHASE},
    '{0, ADDR_POL, 8'h00, RST_POL}, '{0, ADDR_PWR, 8'h00, RST_PWR},
    '{1, ADDR_LOOP, 8'h00, 8'h00}, '{1, ADDR_LOOP, 8'h48, 8'h48}, '{1, ADDR_LOOP, 8'h90, 8'h90},
    '{1, ADDR_LOOP, 8'hD8, 8'hD8}, '{1, ADDR_LOOP, 8'h20, 8'h20}, '{1, ADDR_LOOP, 8'h68, 8'h68},
    '{1, ADDR_LOOP, 8'hB0, 8'hB0}, '{1, ADDR_LOOP, 8'hF8, 8'hF8}, '{1, ADDR_PHASE, 8'hF8, 8'hF8},
    '{1, ADDR_PHASE, 8'h08, 8'h08}, '{1, ADDR_REV, 8'h55, REV_CODE},
    '{1, ADDR_ACT, 8'hFF, 8'h00}, '{1, 8'h20, 8'hAB, 8'h00}};

  ppc_src_model ppc_src_model_inst (.clk(clk), .run(run), .act_high(act_high),
    .period(period), .hsync_pin(hsync_pin));
  ppc_top ppc_top_inst (.clk(clk), .rst_b(rst_b), .hsync_pin(hsync_pin),
    .coast_pin(coast_pin), .aux_sync_act(aux_sync_act), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_ff(reg_rdata_ff),
    .freq_word_ff(freq_word_ff), .loop_lock_ff(loop_lock_ff),
    .sample_phase_ff(sample_phase_ff), .aligned_sync_out_ff(aligned_sync_out_ff),
    .aligned_sync_phase_ff(aligned_sync_phase_ff), .osc_band_field_ff(osc_band_field_ff),
    .pump_current_ff(pump_current_ff), .core_power_on_ff(core_power_on_ff),
    .seek_mode_ff(seek_mode_ff));

  // ****************************************
  // Clock, hang guard and shared tasks
  // ****************************************
  always #25 clk = ~clk;
  // Whole sequence needs about 8700 cycles; over three times that means a hang
  always @(posedge clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      complete_run();
    end
  end
  task automatic complete_run();
    if (mismatches == 0 && comparisons > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic cmp(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
      mismatches++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #5;
  endtask
  // Strobes last one cycle; address and data hold until the taking edge
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk) #5;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1;
    @(posedge clk) #5;
    reg_wr = 0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] exp);
    @(posedge clk) #5;
    reg_addr = a;
    reg_rd = 1;
    @(posedge clk) #5;
    reg_rd = 0;
    cmp(reg_rdata_ff, exp, "read data");
  endtask
  task automatic pwr(input logic core, input logic seek);
    tick(3);
    cmp(core_power_on_ff, core, "full power");
    cmp(seek_mode_ff, seek, "seek mode");
  endtask

  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    tick(6);
    cmp(freq_word_ff, RST_FCW, "reset word");
    cmp({osc_band_field_ff, pump_current_ff, sample_phase_ff}, 12'h0_130, "reset fields");
    cmp({core_power_on_ff, seek_mode_ff}, 2'h0, "reset power");
    rst_b = 1;
    foreach (rows[i]) begin
      if (rows[i].w)
        wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].q);
      if (rows[i].w && rows[i].a === ADDR_LOOP) begin
        cmp(osc_band_field_ff, rows[i].d[7:6], "band");
        cmp(pump_current_ff, rows[i].d[5:3], "pump");
      end
      if (rows[i].w && rows[i].a === ADDR_PHASE)
        cmp(sample_phase_ff, rows[i].d[7:3], "phase");
    end
    // Band must hold the reset word before full power, or the clamp drags it away
    wr(ADDR_LOOP, 8'hA8);
    // Power state from aux detectors and the power-down bit
    pwr(0, 1);
    aux_sync_act = 2'h1;
    pwr(1, 0);
    rd(ADDR_ACT, 8'h02);
    aux_sync_act = 2'h2;
    rd(ADDR_ACT, 8'h10);
    wr(ADDR_PWR, 8'h00);
    pwr(0, 0);
    wr(ADDR_PWR, 8'h02);
    pwr(1, 0);
    aux_sync_act = 2'h0;
    pwr(0, 1);
    // Divisor 1299 makes ratio 1300, which the reset word gives over 400 clocks
    wr(ADDR_DIV_HI, 8'h51);
    wr(ADDR_DIV_LO, 8'h30);
    run = 1;
    tick(4 * period);
    pwr(1, 0);
    rd(ADDR_ACT, 8'h80);
    cmp(freq_word_ff, RST_FCW, "word at ratio");
    cmp(loop_lock_ff, 1'b1, "lock");
    wr(ADDR_DIV_HI, 8'h6F);
    rd(ADDR_DIV_HI, 8'h6F);
    wr(ADDR_DIV_LO, 8'hF0);
    tick(3 * period);
    cmp(freq_word_ff > RST_FCW, 1'b1, "word rises");
    // Coast active high freezes the word; then inverted polarity lets it move
    coast_pin = 1;
    tick(period);
    fw = freq_word_ff;
    tick(3 * period);
    cmp(freq_word_ff, fw, "coast hold");
    wr(ADDR_POL, 8'h40);
    tick(3 * period);
    cmp(freq_word_ff != fw, 1'b1, "coast inactive");
    coast_pin = 0;
    tick(period);
    fw = freq_word_ff;
    tick(3 * period);
    cmp(freq_word_ff, fw, "low coast hold");
    // Active-low sync: aligned copy follows the active level with the phase code
    act_high = 0;
    wr(ADDR_POL, 8'h08);
    wr(ADDR_PHASE, 8'hA8);
    @(negedge hsync_pin);
    tick(8);
    cmp(aligned_sync_out_ff, 1'b1, "aligned active");
    cmp(aligned_sync_phase_ff, 5'h15, "aligned phase");
    @(posedge hsync_pin);
    tick(8);
    cmp(aligned_sync_out_ff, 1'b0, "aligned idle");
    // Sync faster than the accepted range is refused: no lock, word held
    period = 150;
    tick(3 * period);
    fw = freq_word_ff;
    tick(3 * period);
    cmp(freq_word_ff, fw, "short period held");
    cmp(loop_lock_ff, 1'b0, "short period lock");
    complete_run();
  end
endmodule
